// ---- core/prf_core.v ----
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "prf_regs.vh"
module prf_core (
   input  wire        sys_clk,       // 50 MHz clock
   input  wire        srst,          // synchronous reset, high
   input  wire [7:0]  s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output wire        s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // byte enables
   input  wire        s_axi_wvalid,  // write data valid
   output wire        s_axi_wready,  // write data ready
   output wire [1:0]  s_axi_bresp,   // write response
   output wire        s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [7:0]  s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output wire        s_axi_arready, // read address ready
   output wire [31:0] s_axi_rdata,   // read data
   output wire [1:0]  s_axi_rresp,   // read response
   output wire        s_axi_rvalid,  // read data valid
   input  wire        s_axi_rready   // read data ready
);
   // ****************
   // bus state
   // ****************
   reg        awready_r;
   reg        wready_r;
   reg        bvalid_r;
   reg [1:0]  bresp_r;
   reg        arready_r;
   reg        rvalid_r;
   reg [1:0]  rresp_r;
   reg [31:0] rdata_r;
   reg [7:0]  wa_r;
   reg [31:0] wd_r;
   reg [3:0]  ws_r;

   // ****************
   // block state
   // ****************
   reg [31:0] cmd_r;
   reg        go_r;
   reg        done_r;
   reg [15:0] sw_r;
   reg [7:0]  dbuf [0:15];
   reg [63:0] pin_r;
   reg [63:0] rc_r;
   reg [3:0]  rc_try_r;
   reg [1:0]  pin_try_r;
   reg        pin_en_r;
   reg        lvl_ok_r;
   reg [4:0]  keyref_r;
   reg [1:0]  cur_idx_r;
   reg        cur_ok_r;
   reg [15:0] cur_df_r;
   reg        upd_we_r;
   reg [1:0]  upd_idx_r;
   reg        upd_act_r;
   reg [31:0] rd_mux;
   reg        rd_hit;
   reg [1:0]  tgt_idx;
   reg        tgt_ok;
   reg [15:0] fsw;
   integer    i;

   wire        wr_go = !awready_r && !wready_r && !bvalid_r;
   wire [1:0]  op    = cmd_r[1:0];
   wire [7:0]  p1    = cmd_r[15:8];
   wire [7:0]  p2    = cmd_r[23:16];
   wire [4:0]  lc    = cmd_r[28:24];
   wire [4:0]  lcm2  = lc - 5'h02;
   wire [4:0]  lcm1  = lc - 5'h01;
   wire [15:0] look_fid = {dbuf[lcm2[3:0]], dbuf[lcm1[3:0]]};
   wire [63:0] code_in  = {dbuf[0], dbuf[1], dbuf[2], dbuf[3],
                           dbuf[4], dbuf[5], dbuf[6], dbuf[7]};
   wire [63:0] pin_in   = {dbuf[8], dbuf[9], dbuf[10], dbuf[11],
                           dbuf[12], dbuf[13], dbuf[14], dbuf[15]};
   wire [3:0]  rc_dec   = rc_try_r - 4'h1;
   wire        hit;
   wire [1:0]  hit_idx;
   wire [3:0]  act_vec;
   wire [3:0]  keep_vec;
   wire [3:0]  acs_vec;
   wire [3:0]  acr_vec;
   wire [63:0] fid_all;
   wire        cfg_we = wr_go && wa_r == `PRF_OFF_FILE;

   // merge byte lanes of a write into an old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer      k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[8*k +: 8] = st[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
   endfunction

   prf_ftab u_ftab (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .cfg_we    (cfg_we),
      .cfg_idx   (wd_r[1:0]),
      .cfg_fid   (wd_r[31:16]),
      .cfg_flags ({wd_r[4], wd_r[3], wd_r[2], wd_r[5]}),
      .upd_we    (upd_we_r),
      .upd_idx   (upd_idx_r),
      .upd_act   (upd_act_r),
      .look_fid  (look_fid),
      .hit       (hit),
      .hit_idx   (hit_idx),
      .act_vec   (act_vec),
      .keep_vec  (keep_vec),
      .acs_vec   (acs_vec),
      .acr_vec   (acr_vec),
      .fid_all   (fid_all)
   );

   // ****************
   // read decode
   // ****************
   // secrets read as zero; the pin value never leaves the block
   always @*
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      if (s_axi_araddr == `PRF_OFF_CMD)
         rd_mux = cmd_r;
      else if (s_axi_araddr >= `PRF_OFF_DATA0 &&
               s_axi_araddr <= `PRF_OFF_DATA3 &&
               s_axi_araddr[1:0] == 2'h0)
         rd_mux = {dbuf[{s_axi_araddr[3:2] - 2'h1, 2'h3}],
                   dbuf[{s_axi_araddr[3:2] - 2'h1, 2'h2}],
                   dbuf[{s_axi_araddr[3:2] - 2'h1, 2'h1}],
                   dbuf[{s_axi_araddr[3:2] - 2'h1, 2'h0}]};
      else if (s_axi_araddr == `PRF_OFF_RESULT)
         rd_mux = {15'h0000, done_r, sw_r};
      else if (s_axi_araddr == `PRF_OFF_PIN)
         rd_mux = {11'h000, keyref_r, 6'h00, lvl_ok_r, pin_en_r,
                   2'h0, pin_try_r, rc_try_r};
      else if (s_axi_araddr == `PRF_OFF_RCLO ||
               s_axi_araddr == `PRF_OFF_RCHI)
         rd_mux = 32'h0000_0000;
      else if (s_axi_araddr == `PRF_OFF_FILE)
         rd_mux = {16'h0000, acr_vec, acs_vec,
                   act_vec | keep_vec, act_vec};
      else if (s_axi_araddr == `PRF_OFF_CUR)
         rd_mux = {cur_df_r, cur_ok_r ? fid_all[16*cur_idx_r +: 16]
                                      : `PRF_FID_NONE};
      else
         rd_hit = 1'b0;
   end

   // ****************
   // bus slave
   // ****************
   // address and data are taken in either order, one write at a time
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rresp_r   <= 2'h0;
         rdata_r   <= 32'h0000_0000;
         wa_r      <= 8'h00;
         wd_r      <= 32'h0000_0000;
         ws_r      <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && awready_r)
         begin
            wa_r      <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r)
         begin
            wd_r     <= s_axi_wdata;
            ws_r     <= s_axi_wstrb;
            wready_r <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wa_r[1:0] == 2'h0 && wa_r <= `PRF_OFF_CUR &&
                         wa_r != `PRF_OFF_RESULT &&
                         wa_r != `PRF_OFF_CUR) ? 2'h0 : 2'h2;
         end
         if (bvalid_r && s_axi_bready)
         begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
         if (s_axi_arvalid && arready_r)
         begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_hit ? 2'h0 : 2'h2;
         end
         if (rvalid_r && s_axi_rready)
         begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // ****************
   // file target resolution
   // ****************
   // a path only names its last file; intermediate levels are not walked
   always @*
   begin
      tgt_idx = hit_idx;
      tgt_ok  = 1'b0;
      fsw     = `PRF_SW_OK;
      if (p2 != 8'h00 || (p1 != `PRF_P1_FID && p1 != `PRF_P1_ROOT &&
                          p1 != `PRF_P1_CURDIR))
         fsw = `PRF_SW_P1P2;
      else if (lc == 5'h00 && p1 != `PRF_P1_FID)
         fsw = `PRF_SW_LENGTH;
      else if (lc == 5'h00)
      begin
         tgt_idx = cur_idx_r;
         if (!cur_ok_r)
            fsw = `PRF_SW_NOCUR;
      end
      else if ((p1 == `PRF_P1_FID && lc != `PRF_LC_FID) ||
               lc[0] || lc > `PRF_LC_FULL)
         fsw = `PRF_SW_LENGTH;
      else if (!hit)
         fsw = `PRF_SW_NOFILE;
      if (fsw == `PRF_SW_OK)
      begin
         if (op == `PRF_OP_SUSPEND ? !acs_vec[tgt_idx]
                                   : !acr_vec[tgt_idx])
            fsw = `PRF_SW_SECURE;
         else
            tgt_ok = 1'b1;
      end
   end

   // ****************
   // command execution and software writes
   // ****************
   // a command runs in the cycle after its launch write; the next write
   // cannot land before then, so the two never collide
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         cmd_r     <= 32'h0000_0000;
         go_r      <= 1'b0;
         done_r    <= 1'b0;
         sw_r      <= 16'h0000;
         for (i = 0; i < 16; i = i + 1)
            dbuf[i] <= 8'h00;
         pin_r     <= 64'h0000_0000_0000_0000;
         rc_r      <= 64'h0000_0000_0000_0000;
         rc_try_r  <= `PRF_RC_INIT;
         pin_try_r <= `PRF_PIN_INIT;
         pin_en_r  <= 1'b1;
         lvl_ok_r  <= 1'b0;
         keyref_r  <= `PRF_KEYREF_RST;
         cur_idx_r <= 2'h0;
         cur_ok_r  <= 1'b0;
         cur_df_r  <= 16'h0000;
         upd_we_r  <= 1'b0;
         upd_idx_r <= 2'h0;
         upd_act_r <= 1'b0;
      end
      else
      begin
         go_r     <= 1'b0;
         upd_we_r <= 1'b0;
         if (wr_go)
         begin
            if (wa_r == `PRF_OFF_CMD)
            begin
               cmd_r  <= merge(cmd_r, wd_r, ws_r);
               go_r   <= 1'b1;
               done_r <= 1'b0;
            end
            else if (wa_r >= `PRF_OFF_DATA0 && wa_r <= `PRF_OFF_DATA3 &&
                     wa_r[1:0] == 2'h0)
            begin
               for (i = 0; i < 4; i = i + 1)
                  if (ws_r[i])
                     dbuf[{wa_r[3:2] - 2'h1, i[1:0]}] <= wd_r[8*i +: 8];
            end
            else if (wa_r == `PRF_OFF_PIN)
            begin
               // lets software restore counters kept over card sessions
               rc_try_r  <= wd_r[3:0];
               pin_try_r <= wd_r[5:4];
               pin_en_r  <= wd_r[8];
               lvl_ok_r  <= wd_r[9];
               keyref_r  <= wd_r[20:16];
            end
            else if (wa_r == `PRF_OFF_RCLO)
               rc_r[31:0] <= merge(rc_r[31:0], wd_r, ws_r);
            else if (wa_r == `PRF_OFF_RCHI)
               rc_r[63:32] <= merge(rc_r[63:32], wd_r, ws_r);
         end
         if (go_r)
         begin
            done_r <= 1'b1;
            if (op == `PRF_OP_RECOVER)
            begin
               if (p1 != 8'h00)
                  sw_r <= `PRF_SW_P1P2;
               else if (p2[4:0] != keyref_r || p2[7:5] != 3'h0)
                  sw_r <= `PRF_SW_REFDATA;
               else if (lc == 5'h00)
                  sw_r <= {`PRF_SW_TRIES, rc_try_r};
               else if (lc != `PRF_LC_FULL)
                  sw_r <= `PRF_SW_LENGTH;
               else if (rc_try_r == 4'h0)
                  sw_r <= `PRF_SW_BLOCKED;
               else if (code_in == rc_r)
               begin
                  pin_r     <= pin_in;
                  rc_try_r  <= `PRF_RC_INIT;
                  pin_try_r <= `PRF_PIN_INIT;
                  pin_en_r  <= 1'b1;
                  lvl_ok_r  <= 1'b1;
                  sw_r      <= `PRF_SW_OK;
               end
               else
               begin
                  // pin state stays as it is on a wrong code
                  rc_try_r <= rc_dec;
                  sw_r     <= {`PRF_SW_TRIES, rc_dec};
               end
            end
            else if (op == `PRF_OP_SUSPEND || op == `PRF_OP_RESUME)
            begin
               sw_r <= fsw;
               if (tgt_ok)
               begin
                  upd_we_r  <= 1'b1;
                  upd_idx_r <= tgt_idx;
                  upd_act_r <= (op == `PRF_OP_RESUME);
                  cur_idx_r <= tgt_idx;
                  cur_ok_r  <= 1'b1;
               end
               // on failure the current files are left alone
            end
            else
               sw_r <= `PRF_SW_P1P2;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
endmodule

// ---- core/prf_ftab.v ----
`timescale 1ns/100ps
`include "prf_regs.vh"
module prf_ftab (
   input  wire        sys_clk,   // system clock
   input  wire        srst,      // synchronous reset
   input  wire        cfg_we,    // software entry write
   input  wire [1:0]  cfg_idx,   // entry written
   input  wire [15:0] cfg_fid,   // file id of entry
   input  wire [3:0]  cfg_flags, // {keep, acr, acs, act}
   input  wire        upd_we,    // command changes active flag
   input  wire [1:0]  upd_idx,   // entry changed
   input  wire        upd_act,   // new active flag
   input  wire [15:0] look_fid,  // id searched
   output reg         hit,       // id found
   output reg  [1:0]  hit_idx,   // entry found
   output wire [3:0]  act_vec,   // active flags
   output wire [3:0]  keep_vec,  // keep-access flags
   output wire [3:0]  acs_vec,   // suspend allowed
   output wire [3:0]  acr_vec,   // resume allowed
   output wire [63:0] fid_all    // all ids, entry 0 low
);
   reg [15:0] fid_r [0:3];
   reg [3:0]  act_r;
   reg [3:0]  keep_r;
   reg [3:0]  acs_r;
   reg [3:0]  acr_r;
   integer    i, j;

   // ****************
   // entry storage
   // ****************
   // a command update wins over a software write in the same cycle
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         for (i = 0; i < 4; i = i + 1)
            fid_r[i] <= `PRF_FID_NONE;
         act_r  <= 4'h0;
         keep_r <= 4'h0;
         acs_r  <= 4'h0;
         acr_r  <= 4'h0;
      end
      else
      begin
         if (cfg_we)
         begin
            fid_r[cfg_idx]  <= cfg_fid;
            act_r[cfg_idx]  <= cfg_flags[0];
            acs_r[cfg_idx]  <= cfg_flags[1];
            acr_r[cfg_idx]  <= cfg_flags[2];
            keep_r[cfg_idx] <= cfg_flags[3];
         end
         if (upd_we)
            act_r[upd_idx] <= upd_act;
      end
   end

   // lowest matching entry wins
   always @*
   begin
      hit     = 1'b0;
      hit_idx = 2'h0;
      for (j = 3; j >= 0; j = j - 1)
         if (fid_r[j] == look_fid)
         begin
            hit     = 1'b1;
            hit_idx = j[1:0];
         end
   end

   assign act_vec  = act_r;
   assign keep_vec = keep_r;
   assign acs_vec  = acs_r;
   assign acr_vec  = acr_r;
   assign fid_all  = {fid_r[3], fid_r[2], fid_r[1], fid_r[0]};
endmodule

// ---- core/prf_regs.vh ----
`ifndef PRF_REGS_VH
`define PRF_REGS_VH

// ****************
// register offsets
// ****************
`define PRF_OFF_CMD    8'h00
`define PRF_OFF_DATA0  8'h04
`define PRF_OFF_DATA3  8'h10
`define PRF_OFF_RESULT 8'h14
`define PRF_OFF_PIN    8'h18
`define PRF_OFF_RCLO   8'h1C
`define PRF_OFF_RCHI   8'h20
`define PRF_OFF_FILE   8'h24
`define PRF_OFF_CUR    8'h28

// ****************
// opcodes, counts and status words
// ****************
`define PRF_OP_RECOVER 2'h1
`define PRF_OP_SUSPEND 2'h2
`define PRF_OP_RESUME  2'h3
`define PRF_RC_INIT    4'hA
`define PRF_PIN_INIT   2'h3
`define PRF_LC_FULL    5'h10
`define PRF_LC_FID     5'h02
`define PRF_P1_FID     8'h00
`define PRF_P1_ROOT    8'h08
`define PRF_P1_CURDIR  8'h09
`define PRF_SW_OK      16'h9000
`define PRF_SW_TRIES   12'h63C
`define PRF_SW_BLOCKED 16'h6983
`define PRF_SW_SECURE  16'h6982
`define PRF_SW_NOCUR   16'h6986
`define PRF_SW_P1P2    16'h6A86
`define PRF_SW_REFDATA 16'h6A88
`define PRF_SW_NOFILE  16'h6A82
`define PRF_SW_LENGTH  16'h6700
`define PRF_FID_NONE   16'hFFFF
`define PRF_KEYREF_RST 5'h01
`endif

// ---- sim/prf_core_assertions.sv ----
`timescale 1ns/100ps
// ****************
// bus timing checks
// ****************
module prf_core_assertions (
   input wire        sys_clk,       // clock
   input wire        srst,          // synchronous reset
   input wire [7:0]  s_axi_awaddr,  // write address
   input wire        s_axi_awvalid, // write address valid
   input wire        s_axi_awready, // write address ready
   input wire        s_axi_wvalid,  // write data valid
   input wire        s_axi_wready,  // write data ready
   input wire [1:0]  s_axi_bresp,   // write response
   input wire        s_axi_bvalid,  // write response valid
   input wire        s_axi_bready,  // write response ready
   input wire [7:0]  s_axi_araddr,  // read address
   input wire        s_axi_arvalid, // read address valid
   input wire        s_axi_arready, // read address ready
   input wire [31:0] s_axi_rdata,   // read data
   input wire [1:0]  s_axi_rresp,   // read response
   input wire        s_axi_rvalid,  // read data valid
   input wire        s_axi_rready   // read data ready
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // handshakes seen by the checks below that start on a transfer
   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs  = s_axi_wvalid && s_axi_wready;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   a_read_latency: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer not one cycle after address");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer dropped or changed while stalled");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped or changed while stalled");
   a_write_answer: assert property (aw_hs && w_hs |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   // the status register must refuse software writes
   a_ro_refused: assert property (aw_hs && w_hs && s_axi_awaddr == 8'h14
      |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'b10)
      else $error("status write not refused");
   a_hole_read: assert property (ar_hs && s_axi_araddr > 8'h28 |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   // stored codes must never leak back to software
   a_code_hidden: assert property (ar_hs && (s_axi_araddr == 8'h1C ||
      s_axi_araddr == 8'h20) |=> s_axi_rdata == 32'h0000_0000)
      else $error("recovery code readable");
   a_idle_reset: assert property ($fell(srst) |-> s_axi_awready &&
      s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
      else $error("bus not idle after reset");
   c_cmd_write: cover property (aw_hs && w_hs && s_axi_awaddr == 8'h00);
   c_status_rd: cover property (ar_hs && s_axi_araddr == 8'h14);
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind prf_core prf_core_assertions u_chk (
   .sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- sim/prf_core_tb_top.sv ----
`timescale 1ns/100ps
// ****************
// bench top
// ****************
module prf_core_tb_top;
   reg          sys_clk;
   reg          srst;
   wire [7:0]   s_axi_awaddr, s_axi_araddr;
   wire [31:0]  s_axi_wdata, s_axi_rdata;
   wire [3:0]   s_axi_wstrb;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   wire         s_axi_rvalid, s_axi_rready, timed_out;
   integer      n_errors, checked, k, n, t;
   reg [33:0]   exp_r[$];
   reg [1:0]    exp_b[$];
   reg [63:0]   rc, np;
   reg [127:0]  rnd;
   prf_core dut (.sys_clk(sys_clk), .srst(srst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   prf_term term (.sys_clk(sys_clk),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .timed_out(timed_out));
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task end_of_test;
      begin
         $display("errors %0d checks %0d", n_errors, checked);
         if (n_errors == 0 && checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task cmp(input [33:0] got, input [33:0] want);
      begin
         checked = checked + 1;
         if (got !== want)
         begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
         end
      end
   endtask
   // monitor at the falling edge, where the bus is settled
   always @(negedge sys_clk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         cmp({s_axi_rresp, s_axi_rdata}, exp_r.size() ? exp_r.pop_front() : 'x);
      if (s_axi_bvalid && s_axi_bready)
         cmp({32'h0, s_axi_bresp}, exp_b.size() ? {32'h0, exp_b.pop_front()} : 'x);
   end
   // one bound for a hung handshake or run
   initial
   begin
      for (t = 0; t < 40000 && timed_out !== 1'b1; t = t + 1)
         @(posedge sys_clk);
      n_errors = n_errors + 1;
      end_of_test;
   end
   task rd_exp(input [7:0] a, input [33:0] w);
      begin
         exp_r.push_back(w);
         term.rd(a);
      end
   endtask
   task wr_exp(input [7:0] a, input [31:0] d, input [1:0] r);
      begin
         exp_b.push_back(r);
         term.wr(a, d);
      end
   endtask
   // data bytes in send order, byte 0 in the top bits of b
   task load(input [127:0] b);
      reg [31:0] w;
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            w = b[127 - 32 * k -: 32];
            wr_exp(8'h04 + 4 * k, {w[7:0], w[15:8], w[23:16], w[31:24]}, 0);
         end
      end
   endtask
   task run(input [1:0] op, input [7:0] p1, input [4:0] lc, input [15:0] sw);
      begin
         exp_b.push_back(2'b00);
         term.cmd(op, p1, (op == 2'h1) ? 8'h01 : 8'h00, lc);
         rd_exp(8'h14, {18'h1, sw});
      end
   endtask
   task ftest(input [1:0] op, input [7:0] p1, input [4:0] lc,
      input [127:0] b, input [15:0] sw, input [15:0] fv, input [15:0] cur);
      begin
         load(b);
         run(op, p1, lc, sw);
         rd_exp(8'h24, {18'h0, fv});
         rd_exp(8'h28, {18'h0, cur});
      end
   endtask
   initial
   begin
      n_errors = 0;
      checked = 0;
      srst = 1'b1;
      void'($urandom(33869));
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rd_exp(8'h18, 34'h0_0001_013A);
      rd_exp(8'h28, 34'h0_0000_FFFF);
      rd_exp(8'h30, 34'h2_0000_0000);
      wr_exp(8'h14, 32'h0000_0000, 2'b10);
      rc = {$urandom, $urandom};
      np = {$urandom, $urandom};
      wr_exp(8'h20, rc[63:32], 2'b00);
      wr_exp(8'h1C, rc[31:0], 2'b00);
      rd_exp(8'h1C, 34'h0_0000_0000);
      run(2'h1, 8'h00, 5'd0, 16'h63CA);
      // ten wrong codes in a row, then the blocked code refuses
      for (n = 9; n >= 0; n = n - 1)
      begin
         load({rc ^ 64'h1, np});
         run(2'h1, 8'h00, 5'd16, {12'h63C, n[3:0]});
         rd_exp(8'h18, {30'h0_0001_013, n[3:0]});
      end
      load({rc, np});
      run(2'h1, 8'h00, 5'd16, 16'h6983);
      run(2'h1, 8'h00, 5'd0, 16'h63C0);
      run(2'h1, 8'h01, 5'd16, 16'h6A86);
      // pin blocked, code live: recovery must still succeed
      wr_exp(8'h18, 32'h0001_0105, 2'b00);
      run(2'h1, 8'h00, 5'd16, 16'h9000);
      rd_exp(8'h18, 34'h0_0001_033A);
      wr_exp(8'h24, 32'h2F01_002C, 2'b00);
      wr_exp(8'h24, 32'h6F07_003D, 2'b00);
      wr_exp(8'h24, 32'h6F10_0022, 2'b00);
      rd_exp(8'h24, 34'h0_0000_3377);
      rnd = {$urandom, $urandom, $urandom, $urandom};
      ftest(2, 8'h00, 2, {16'h2F01, rnd[111:0]}, 16'h9000, 16'h3366, 16'h2F01);
      ftest(2, 8'h00, 2, {16'h6F10, rnd[111:0]}, 16'h6982, 16'h3366, 16'h2F01);
      ftest(2, 8'h04, 2, {16'h6F07, rnd[111:0]}, 16'h6A86, 16'h3366, 16'h2F01);
      ftest(2, 8'h00, 3, {16'h6F07, rnd[111:0]}, 16'h6700, 16'h3366, 16'h2F01);
      ftest(3, 8'h00, 0, rnd, 16'h9000, 16'h3377, 16'h2F01);
      ftest(2, 8'h08, 4, {32'h3F00_6F07, rnd[95:0]}, 16'h9000, 16'h3375, 16'h6F07);
      ftest(3, 8'h09, 2, {16'h6F07, rnd[111:0]}, 16'h9000, 16'h3377, 16'h6F07);
      ftest(3, 8'h00, 2, {16'h1234, rnd[111:0]}, 16'h6A82, 16'h3377, 16'h6F07);
      // mid-run reset restores the counters
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      rd_exp(8'h18, 34'h0_0001_013A);
      run(3, 8'h00, 0, 16'h6986);
      repeat (4) @(posedge sys_clk);
      end_of_test;
   end
endmodule

// ---- sim/prf_term.sv ----
`timescale 1ns/100ps
// ****************
// terminal model, bus master
// ****************
module prf_term (
   input  wire        sys_clk,       // clock
   output reg  [7:0]  s_axi_awaddr,  // write address
   output reg         s_axi_awvalid, // write address valid
   input  wire        s_axi_awready, // write address ready
   output reg  [31:0] s_axi_wdata,   // write data
   output reg  [3:0]  s_axi_wstrb,   // byte enables
   output reg         s_axi_wvalid,  // write data valid
   input  wire        s_axi_wready,  // write data ready
   input  wire        s_axi_bvalid,  // write response valid
   output reg         s_axi_bready,  // write response ready
   output reg  [7:0]  s_axi_araddr,  // read address
   output reg         s_axi_arvalid, // read address valid
   input  wire        s_axi_arready, // read address ready
   input  wire        s_axi_rvalid,  // read data valid
   output reg         s_axi_rready,  // read data ready
   output reg         timed_out      // a wait ran out
);
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
      s_axi_wstrb = 4'hF;
      timed_out = 1'b0;
   end
   // ready is raised late at random so the slave must hold its answer
   task take(input rd);
      integer n;
      reg     seen;
      begin
         repeat ($urandom_range(2)) @(posedge sys_clk);
         if (rd) s_axi_rready <= 1'b1;
         else s_axi_bready <= 1'b1;
         seen = 1'b0;
         for (n = 0; n < 64 && !seen; n = n + 1)
         begin
            @(negedge sys_clk);
            seen = rd ? s_axi_rvalid : s_axi_bvalid;
            @(posedge sys_clk);
         end
         s_axi_rready <= 1'b0;
         s_axi_bready <= 1'b0;
         if (!seen) timed_out <= 1'b1;
      end
   endtask
   // address and data offered together, each released when taken
   task wr(input [7:0] a, input [31:0] d);
      integer n;
      reg     pa;
      reg     pw;
      begin
         @(posedge sys_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         pa = 1'b1;
         pw = 1'b1;
         for (n = 0; n < 64 && (pa || pw); n = n + 1)
         begin
            @(negedge sys_clk);
            if (s_axi_awready) pa = 1'b0;
            if (s_axi_wready) pw = 1'b0;
            @(posedge sys_clk);
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
         end
         if (pa || pw) timed_out <= 1'b1;
         take(1'b0);
      end
   endtask
   task rd(input [7:0] a);
      integer n;
      reg     seen;
      begin
         @(posedge sys_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         seen = 1'b0;
         for (n = 0; n < 64 && !seen; n = n + 1)
         begin
            @(negedge sys_clk);
            seen = s_axi_arready;
            @(posedge sys_clk);
         end
         s_axi_arvalid <= 1'b0;
         if (!seen) timed_out <= 1'b1;
         take(1'b1);
      end
   endtask
   // command header: pin chosen in p2, no le, lc taken as given into bits 28:24
   task cmd(input [1:0] op, input [7:0] p1, input [7:0] p2, input [4:0] lc);
      wr(8'h00, {3'b000, lc, p2, p1, 6'b00_0000, op});
   endtask
endmodule
